// ==== core/fsps_pkg.sv ====
/*
 Package for the flash self-program sequencer: register map, control bit positions,
 command patterns, flash geometry and timing constants.
 Assumes a 200 MHz pclk and an APB register port with 32-bit data.
*/
package fsps_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_POINTER = 12'h004;
   localparam logic [11:0] OFS_DATA = 12'h008;
   localparam logic [11:0] OFS_STORE = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_LOCKS = 12'h014;
   localparam logic [11:0] OFS_READ = 12'h018;
   localparam logic [11:0] OFS_ROM = 12'h01C;

   // ----------------------------------------------------------------
   // Control register bits
   // ----------------------------------------------------------------
   localparam int BIT_ENABLE = 0;
   localparam int BIT_ERASE = 1;
   localparam int BIT_WRITE = 2;
   localparam int BIT_LOCKSET = 3;
   localparam int BIT_REENABLE = 4;
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_BUSY = 6;

   // Command patterns, bit 7 excluded from the compare except for the 8-bit CMD_LOAD_FULL
   localparam logic [6:0] CMD_ERASE = 7'h03;
   localparam logic [6:0] CMD_LOAD = 7'h01;
   localparam logic [6:0] CMD_WRITE = 7'h05;
   localparam logic [6:0] CMD_LOCK = 7'h09;
   localparam logic [6:0] CMD_REEN = 7'h11;
   localparam logic [7:0] CMD_LOAD_FULL = 8'h01;

   // ----------------------------------------------------------------
   // Flash geometry
   // ----------------------------------------------------------------
   localparam int WORD_BITS = 6;
   localparam int PAGE_WORDS = 64;
   localparam int PAGE_BITS = 8;
   localparam int ADDR_BITS = 16;
   localparam logic [PAGE_BITS-1:0] HALT_PAGE_FIRST = 8'hE0;
   localparam logic [15:0] BOOT_START_WORD = 16'h3800;
   localparam logic [15:0] APP_START_WORD = 16'h0000;
   localparam logic [3:0] LOCK_RESET = 4'hF;
   localparam int LOCK_LSB = 2;
   localparam int LOCK_MSB = 5;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int WINDOW_CYCLES = 4;
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
   localparam int PROG_CNT_W = 20;

   typedef enum logic [1:0] {
      FSPS_IDLE = 2'b00,
      FSPS_ARMED = 2'b01,
      FSPS_PROG = 2'b10
   } fsps_state_t;
endpackage : fsps_pkg

// ==== core/fsps_page_buf.sv ====
/*
 Temporary page buffer: one 16-bit word per page location, written at random
 index, cleared whole in one cycle. Assumes the caller loads each index once.
*/
`timescale 1ns/1ps
module fsps_page_buf (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic load,
   input wire logic [fsps_pkg::WORD_BITS-1:0] load_idx,
   input wire logic [15:0] load_word,
   input wire logic [fsps_pkg::WORD_BITS-1:0] rd_idx,
   output logic [15:0] rd_word
);
   logic [15:0] mem_q [fsps_pkg::PAGE_WORDS];

   // ----------------------------------------------------------------
   // Storage, erased state is all ones
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < fsps_pkg::PAGE_WORDS; gi++) begin : g_word
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_q[gi] <= 16'hFFFF;
            end else if (clk_en) begin
               if (clear) begin
                  mem_q[gi] <= 16'hFFFF;
               end else if (load && load_idx == fsps_pkg::WORD_BITS'(gi)) begin
                  mem_q[gi] <= load_word;
               end
            end
         end
      end
   endgenerate

   assign rd_word = mem_q[rd_idx];
endmodule : fsps_page_buf

// ==== core/fsps_top.sv ====
/*
 Flash self-program sequencer with APB register port. Holds the control register,
 address pointer, data pair, timed command window, page buffer, programming
 timer, busy flag, halt request, ready interrupt level while idle and a small flash model
 write port. Assumes the boot vector fuse and EEPROM busy are asynchronous pins.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module fsps_top #(
   parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_vector_fuse,
   input wire logic eeprom_write_busy,
   output logic [15:0] reset_vector,
   output logic cpu_halt,
   output logic irq,
   output logic concurrent_section_busy,
   output logic flash_we,
   output logic flash_erase,
   output logic [fsps_pkg::PAGE_BITS-1:0] flash_page
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   fsps_pkg::fsps_state_t state_q;
   logic [7:0] ctrl_q;
   logic [15:0] pointer_q;
   logic [15:0] data_q;
   logic [fsps_pkg::PAGE_BITS-1:0] page_q;
   logic [6:0] op_q;
   logic [2:0] win_q;
   logic [fsps_pkg::PROG_CNT_W-1:0] tmr_q;
   logic [3:0] locks_q;
   logic [3:0] lock_data_q;
   logic [7:0] rom_byte_q;
   logic [1:0] fuse_sync_q;
   logic [1:0] fuse_vld_q;
   logic [1:0] ee_sync_q;
   logic fuse_seen_q;
   logic halt_q;
   logic busy_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic pready_q;
   logic we_q;
   logic erase_q;
   logic [15:0] rv_q;
   logic loaded_q;
   logic buf_clear;
   logic buf_load;
   logic [15:0] buf_word;
   logic wr_acc;
   logic rd_acc;
   logic store;
   logic start_prog;
   logic done;
   logic ee_busy;
   logic [6:0] cmd;

   function automatic logic is_prog_cmd(input logic [6:0] c);
      return c == fsps_pkg::CMD_ERASE || c == fsps_pkg::CMD_WRITE || c == fsps_pkg::CMD_LOCK;
   endfunction : is_prog_cmd

   function automatic logic in_halt_section(input logic [fsps_pkg::PAGE_BITS-1:0] p);
      return p >= fsps_pkg::HALT_PAGE_FIRST;
   endfunction : in_halt_section

   // ----------------------------------------------------------------
   // APB decode, zero wait states
   // ----------------------------------------------------------------
   assign wr_acc = psel && penable && pwrite && pready_q;
   assign rd_acc = psel && !pwrite && !penable;
   assign store = wr_acc && paddr == fsps_pkg::OFS_STORE;
   assign cmd = ctrl_q[6:0];
   assign ee_busy = ee_sync_q[1];
   assign done = state_q == fsps_pkg::FSPS_PROG && tmr_q == '0;
   assign start_prog = store && state_q == fsps_pkg::FSPS_ARMED && is_prog_cmd(cmd) && !ee_busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= psel && !penable;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_sync_q <= 2'b11;
         fuse_vld_q <= 2'b00;
         ee_sync_q <= 2'b00;
      end else if (clk_en) begin
         fuse_sync_q <= {fuse_sync_q[0], boot_vector_fuse};
         fuse_vld_q <= {fuse_vld_q[0], 1'b1};
         ee_sync_q <= {ee_sync_q[0], eeprom_write_busy};
      end
   end

   // Reset vector captured once after release; read only, no write path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_seen_q <= 1'b0;
         rv_q <= fsps_pkg::APP_START_WORD;
      end else if (clk_en && fuse_vld_q[1] && !fuse_seen_q) begin
         fuse_seen_q <= 1'b1;
         rv_q <= fuse_sync_q[1] ? fsps_pkg::APP_START_WORD : fsps_pkg::BOOT_START_WORD;
      end
   end

   // ----------------------------------------------------------------
   // Software registers: pointer and data pair
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pointer_q <= '0;
         data_q <= '0;
      end else if (clk_en && wr_acc) begin
         if (paddr == fsps_pkg::OFS_POINTER) begin
            pointer_q <= pwdata[15:0];
         end
         if (paddr == fsps_pkg::OFS_DATA) begin
            data_q <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer: timed window, programming timer, enable bit
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= fsps_pkg::FSPS_IDLE;
         ctrl_q <= '0;
         win_q <= '0;
         tmr_q <= '0;
         op_q <= '0;
         page_q <= '0;
         lock_data_q <= fsps_pkg::LOCK_RESET;
      end else if (clk_en) begin
         unique case (state_q)
            fsps_pkg::FSPS_IDLE: begin
               if (wr_acc && paddr == fsps_pkg::OFS_CONTROL) begin
                  ctrl_q <= pwdata[7:0];
                  if (pwdata[fsps_pkg::BIT_ENABLE]) begin
                     state_q <= fsps_pkg::FSPS_ARMED;
                     win_q <= 3'(fsps_pkg::WINDOW_CYCLES);
                  end
               end
            end
            fsps_pkg::FSPS_ARMED: begin
               if (start_prog) begin
                  state_q <= fsps_pkg::FSPS_PROG;
                  op_q <= cmd;
                  page_q <= pointer_q[fsps_pkg::ADDR_BITS-2 -: fsps_pkg::PAGE_BITS];
                  lock_data_q <= data_q[fsps_pkg::LOCK_MSB:fsps_pkg::LOCK_LSB];
                  tmr_q <= fsps_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
               end else if (store || win_q == 3'h1) begin
                  state_q <= fsps_pkg::FSPS_IDLE;
                  ctrl_q[5:0] <= 6'h00;
               end else begin
                  win_q <= win_q - 3'h1;
               end
            end
            fsps_pkg::FSPS_PROG: begin
               if (done) begin
                  state_q <= fsps_pkg::FSPS_IDLE;
                  ctrl_q[5:0] <= 6'h00;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            default: begin
               state_q <= fsps_pkg::FSPS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Page buffer control
   // ----------------------------------------------------------------
   assign buf_load = store && state_q == fsps_pkg::FSPS_ARMED && ctrl_q == fsps_pkg::CMD_LOAD_FULL
      && !ee_busy;
   assign buf_clear = (done && op_q == fsps_pkg::CMD_WRITE)
      || (store && state_q == fsps_pkg::FSPS_ARMED && cmd == fsps_pkg::CMD_REEN)
      || (ee_busy && loaded_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_q <= 1'b0;
      end else if (clk_en) begin
         if (buf_load) begin
            loaded_q <= 1'b1;
         end else if (buf_clear) begin
            loaded_q <= 1'b0;
         end
      end
   end

   fsps_page_buf u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .clear(buf_clear),
      .load(buf_load),
      .load_idx(pointer_q[fsps_pkg::WORD_BITS:1]),
      .load_word(data_q),
      .rd_idx(pointer_q[fsps_pkg::WORD_BITS:1]),
      .rd_word(buf_word)
   );

   // ----------------------------------------------------------------
   // Lock bits, busy flag, halt, flash strobes
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locks_q <= fsps_pkg::LOCK_RESET;
      end else if (clk_en && done && op_q == fsps_pkg::CMD_LOCK) begin
         locks_q <= locks_q & lock_data_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         halt_q <= 1'b0;
      end else if (clk_en) begin
         if (start_prog && cmd != fsps_pkg::CMD_LOCK) begin
            busy_q <= !in_halt_section(pointer_q[fsps_pkg::ADDR_BITS-2 -: fsps_pkg::PAGE_BITS]);
            halt_q <= in_halt_section(pointer_q[fsps_pkg::ADDR_BITS-2 -: fsps_pkg::PAGE_BITS]);
         end else if (done) begin
            halt_q <= 1'b0;
         end else if (store && state_q == fsps_pkg::FSPS_ARMED && cmd == fsps_pkg::CMD_REEN) begin
            busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         we_q <= 1'b0;
         erase_q <= 1'b0;
      end else if (clk_en) begin
         we_q <= done && op_q == fsps_pkg::CMD_WRITE;
         erase_q <= done && op_q == fsps_pkg::CMD_ERASE;
      end
   end

   // Interrupt level while enabled and enable bit clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= ctrl_q[fsps_pkg::BIT_IRQ_EN] && state_q == fsps_pkg::FSPS_IDLE && !done;
      end
   end

   // ----------------------------------------------------------------
   // Byte read from buffer view and read data
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_byte_q <= '0;
      end else if (clk_en) begin
         rom_byte_q <= pointer_q[0] ? buf_word[15:8] : buf_word[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pslverr_q <= 1'b0;
         if (rd_acc) begin
         unique case (paddr)
            fsps_pkg::OFS_CONTROL: prdata_q <= {24'h0, ctrl_q[7], busy_q, ctrl_q[5:1],
               state_q != fsps_pkg::FSPS_IDLE};
            fsps_pkg::OFS_POINTER: prdata_q <= {16'h0, pointer_q};
            fsps_pkg::OFS_DATA: prdata_q <= {16'h0, data_q};
            fsps_pkg::OFS_STORE: prdata_q <= '0;
            fsps_pkg::OFS_STATUS: prdata_q <= {27'h0, irq_q, halt_q, busy_q, state_q};
            fsps_pkg::OFS_LOCKS: prdata_q <= {28'h0, locks_q};
            fsps_pkg::OFS_READ: prdata_q <= {16'h0, buf_word};
            fsps_pkg::OFS_ROM: prdata_q <= {24'h0, rom_byte_q};
            default: begin
               prdata_q <= '0;
               pslverr_q <= 1'b1;
            end
         endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign reset_vector = rv_q;
   assign cpu_halt = halt_q;
   assign irq = irq_q;
   assign concurrent_section_busy = busy_q;
   assign flash_we = we_q;
   assign flash_erase = erase_q;
   assign flash_page = page_q;
endmodule : fsps_top

// ==== dv/fsps_monitor.sv ====
/* Port checker for fsps_top.
   Assumes the fuse pin only changes while presetn is low. */
`timescale 1ns/1ps
module fsps_monitor #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic boot_vector_fuse,
   input wire logic [15:0] reset_vector,
   input wire logic cpu_halt,
   input wire logic irq,
   input wire logic concurrent_section_busy,
   input wire logic flash_we,
   input wire logic flash_erase,
   input wire logic [fsps_pkg::PAGE_BITS-1:0] flash_page
);
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   logic [1:0] vcnt_q;
   logic [19:0] hcnt_q;
   logic store_wr;
   assign store_wr = psel && penable && pready && pwrite && paddr == fsps_pkg::OFS_STORE;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) vcnt_q <= 2'h0;
      else if (vcnt_q != 2'h3) vcnt_q <= vcnt_q + 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hcnt_q <= 20'h0;
      else hcnt_q <= cpu_halt ? hcnt_q + 20'h1 : 20'h0;
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_vec_fuse: assert property (vcnt_q == 2'h3 |-> reset_vector ==
      (boot_vector_fuse ? fsps_pkg::APP_START_WORD : fsps_pkg::BOOT_START_WORD))
      else $error("reset vector does not follow fuse");
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_err_read: assert property (pslverr |-> pready && !pwrite)
      else $error("error outside read access");
   a_erase_pulse: assert property (flash_erase |=> !flash_erase)
      else $error("erase pulse too long");
   a_write_pulse: assert property (flash_we |=> !flash_we)
      else $error("write pulse too long");
   a_op_excl: assert property (!(flash_we && flash_erase))
      else $error("erase and write together");
   a_halt_page: assert property (cpu_halt && $past(cpu_halt) |-> flash_page >= fsps_pkg::HALT_PAGE_FIRST)
      else $error("halt on concurrent page");
   a_page_latch: assert property (cpu_halt && $past(cpu_halt) |-> $stable(flash_page))
      else $error("page moved during operation");
   a_halt_len: assert property ($fell(cpu_halt) |-> hcnt_q >= PROG_CYCLES - 2 && hcnt_q <= PROG_CYCLES + 2)
      else $error("halt length wrong");
   a_irq_quiet: assert property (cpu_halt && $past(cpu_halt) |-> !irq)
      else $error("irq while busy");
   a_busy_clear: assert property ($fell(concurrent_section_busy) |-> $past(store_wr) || $past(store_wr, 2))
      else $error("busy cleared without store");
endmodule : fsps_monitor

// ==== dv/fsps_cpu_model.sv ====
/* Boot loader CPU model: APB master with timed command pairs.
   Tasks are entered just after a rising pclk edge. */
`timescale 1ns/1ps
module fsps_cpu_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   logic last_err;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      last_err = 1'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic keep,
                       output logic [31:0] q);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      last_err = pslverr;
      if (!keep) begin
         psel <= 1'h0;
         penable <= 1'h0;
         pwdata <= ~d;
         @(posedge pclk);
      end
   endtask : xfer
   // Control then store back to back, unless a gap is asked for
   task automatic spm(input logic [7:0] cmd, input int gap);
      logic [31:0] x;
      xfer(1'h1, fsps_pkg::OFS_CONTROL, {24'h0, cmd}, gap == 0, x);
      repeat (gap) @(posedge pclk);
      xfer(1'h1, fsps_pkg::OFS_STORE, 32'h0, 1'h0, x);
   endtask : spm
   task automatic load(input logic [15:0] p, input logic [15:0] w);
      logic [31:0] x;
      xfer(1'h1, fsps_pkg::OFS_POINTER, {16'h0, p}, 1'h0, x);
      xfer(1'h1, fsps_pkg::OFS_DATA, {16'h0, w}, 1'h0, x);
      spm(fsps_pkg::CMD_LOAD_FULL, 0);
   endtask : load
   // Unused lock data bits 7:6 and 1:0 kept at one, bits 15:8 at zero
   task automatic lock(input logic [15:0] p, input logic [3:0] b);
      logic [31:0] x;
      xfer(1'h1, fsps_pkg::OFS_POINTER, {16'h0, p}, 1'h0, x);
      xfer(1'h1, fsps_pkg::OFS_DATA, {24'h0, 2'h3, b, 2'h3}, 1'h0, x);
      spm(8'h09, 0);
   endtask : lock
endmodule : fsps_cpu_model

// ==== dv/flash_self_program_sequencer_bench.sv ====
/* Self-checking bench for fsps_top with a CPU model on APB.
   Assumes fsps_pkg and the monitor are compiled first. */
`timescale 1ns/1ps
module flash_self_program_sequencer_bench;
   localparam int PC = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, boot_vector_fuse, eeprom_write_busy;
   logic cpu_halt, irq, concurrent_section_busy, flash_we, flash_erase;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] reset_vector;
   logic [7:0] flash_page, last_page;
   int fails = 0, n_tests = 0, n_erase = 0, n_write = 0, cyc = 0;
   fsps_top #(.PROG_CYCLES(PC)) fsps_top_inst (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_vector_fuse, .eeprom_write_busy, .reset_vector,
      .cpu_halt, .irq, .concurrent_section_busy, .flash_we, .flash_erase, .flash_page);
   fsps_cpu_model fsps_cpu_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (flash_erase === 1'h1) n_erase <= n_erase + 1;
      if (flash_we === 1'h1) n_write <= n_write + 1;
      if (flash_erase === 1'h1 || flash_we === 1'h1) last_page <= flash_page;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdr(input logic [11:0] a);
      fsps_cpu_model_inst.xfer(1'h0, a, 32'h0, 1'h0, rd);
   endtask : rdr
   task automatic wrr(input logic [11:0] a, input logic [31:0] d);
      fsps_cpu_model_inst.xfer(1'h1, a, d, 1'h0, rd);
   endtask : wrr
   task automatic cmd(input logic [7:0] c, input int gap);
      fsps_cpu_model_inst.spm(c, gap);
   endtask : cmd
   function automatic logic [31:0] ptr(input logic [7:0] pg, input logic [5:0] w, input logic b);
      return {16'h0, 1'h0, pg, w, b};
   endfunction : ptr
   task automatic wait_done;
      do rdr(fsps_pkg::OFS_CONTROL); while (rd[0] !== 1'h0);
   endtask : wait_done
   task automatic do_reset(input logic f);
      @(posedge pclk);
      presetn <= 1'h0;
      boot_vector_fuse <= f;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      repeat (4) @(posedge pclk);
   endtask : do_reset
   task automatic summarize;
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_vector;
      do_reset(1'h0);
      chk("vec_boot", 32'h3800, {16'h0, reset_vector});
      wrr(fsps_pkg::OFS_ROM, 32'hFFFFFFFF);
      chk("vec_kept", 32'h3800, {16'h0, reset_vector});
      do_reset(1'h1);
      chk("vec_app", 32'h0, {16'h0, reset_vector});
      rdr(12'h0FC);
      chk("unmapped", 32'h1, {31'h0, fsps_cpu_model_inst.last_err});
      $display("t_vector done");
   endtask : t_vector
   task automatic t_buffer;
      logic [5:0] idx [3] = '{6'h05, 6'h02, 6'h3F};
      for (int i = 0; i < 3; i++) fsps_cpu_model_inst.load(ptr(8'h10, idx[i], 1'h0), 16'hA500 + i);
      for (int i = 0; i < 3; i++) begin
         wrr(fsps_pkg::OFS_POINTER, ptr(8'h10, idx[i], 1'h0));
         rdr(fsps_pkg::OFS_READ);
         chk("buf_word", 32'hA500 + i, rd);
      end
      rdr(fsps_pkg::OFS_ROM);
      chk("byte_lo", 32'h02, rd);
      wrr(fsps_pkg::OFS_POINTER, ptr(8'h10, 6'h3F, 1'h1));
      rdr(fsps_pkg::OFS_ROM);
      chk("byte_hi", 32'hA5, rd);
      cmd(8'h11, 0);
      wait_done();
      rdr(fsps_pkg::OFS_READ);
      chk("buf_clear_reen", 32'hFFFF, rd);
      $display("t_buffer done");
   endtask : t_buffer
   task automatic t_prog;
      int s, ne;
      fsps_cpu_model_inst.load(ptr(8'h10, 6'h00, 1'h0), 16'hBEEF);
      ne = n_erase;
      cmd(8'h03, 0);
      s = cyc;
      wrr(fsps_pkg::OFS_POINTER, ptr(8'h22, 6'h00, 1'h0));
      rdr(fsps_pkg::OFS_CONTROL);
      chk("en_held", 32'h1, {31'h0, rd[0]});
      chk("busy_on", 32'h1, {31'h0, concurrent_section_busy});
      chk("no_halt", 32'h0, {31'h0, cpu_halt});
      wait_done();
      chk("duration", 32'h1, {31'h0, cyc - s >= PC - 2 && cyc - s <= PC + 6});
      chk("erase_cnt", ne + 1, n_erase);
      chk("erase_page", 32'h10, {24'h0, last_page});
      chk("busy_kept", 32'h1, {31'h0, concurrent_section_busy});
      wrr(fsps_pkg::OFS_POINTER, ptr(8'h10, 6'h00, 1'h0));
      cmd(8'h05, 0);
      wait_done();
      chk("write_page", 32'h10, {24'h0, last_page});
      rdr(fsps_pkg::OFS_READ);
      chk("buf_clear_wr", 32'hFFFF, rd);
      cmd(8'h11, 0);
      wait_done();
      chk("busy_off", 32'h0, {31'h0, concurrent_section_busy});
      $display("t_prog done");
   endtask : t_prog
   task automatic t_halt;
      wrr(fsps_pkg::OFS_POINTER, ptr(8'hE0, 6'h00, 1'h0));
      cmd(8'h03, 0);
      chk("halt_on", 32'h1, {31'h0, cpu_halt});
      wait_done();
      chk("halt_off", 32'h0, {31'h0, cpu_halt});
      chk("halt_page", 32'hE0, {24'h0, last_page});
      $display("t_halt done");
   endtask : t_halt
   task automatic t_lock;
      fsps_cpu_model_inst.lock(16'hFFFF, 4'h5);
      chk("lock_nohalt", 32'h0, {31'h0, cpu_halt});
      chk("lock_nobusy", 32'h0, {31'h0, concurrent_section_busy});
      wait_done();
      rdr(fsps_pkg::OFS_LOCKS);
      chk("locks", 32'h5, {28'h0, rd[3:0]});
      $display("t_lock done");
   endtask : t_lock
   task automatic t_guard;
      int ne;
      ne = n_erase;
      wrr(fsps_pkg::OFS_POINTER, ptr(8'h11, 6'h00, 1'h0));
      cmd(8'h03, 6);
      rdr(fsps_pkg::OFS_CONTROL);
      chk("auto_clear", 32'h0, {28'h0, rd[3:0]});
      cmd(8'h07, 0);
      fsps_cpu_model_inst.load(ptr(8'h11, 6'h04, 1'h0), 16'h1234);
      eeprom_write_busy <= 1'h1;
      cmd(8'h03, 0);
      eeprom_write_busy <= 1'h0;
      repeat (PC + 4) @(posedge pclk);
      chk("no_erase", ne, n_erase);
      wrr(fsps_pkg::OFS_POINTER, ptr(8'h11, 6'h04, 1'h0));
      rdr(fsps_pkg::OFS_READ);
      chk("buf_dropped", 32'hFFFF, rd);
      $display("t_guard done");
   endtask : t_guard
   task automatic t_irq;
      wrr(fsps_pkg::OFS_CONTROL, 32'h80);
      @(posedge pclk);
      chk("irq_idle", 32'h1, {31'h0, irq});
      wrr(fsps_pkg::OFS_POINTER, ptr(8'h12, 6'h00, 1'h0));
      cmd(8'h83, 0);
      chk("irq_busy", 32'h0, {31'h0, irq});
      wait_done();
      chk("irq_done", 32'h1, {31'h0, irq});
      cmd(8'h91, 0);
      wait_done();
      wrr(fsps_pkg::OFS_CONTROL, 32'h0);
      @(posedge pclk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      $display("t_irq done");
   endtask : t_irq
   initial begin
      presetn = 1'h0;
      boot_vector_fuse = 1'h1;
      eeprom_write_busy = 1'h0;
      do_reset(1'h1);
      t_vector();
      t_buffer();
      t_prog();
      t_halt();
      t_lock();
      t_guard();
      t_irq();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      summarize();
   end
endmodule : flash_self_program_sequencer_bench

bind fsps_top fsps_monitor #(.PROG_CYCLES(PROG_CYCLES)) fsps_monitor_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pready, .pslverr, .boot_vector_fuse, .reset_vector, .cpu_halt, .irq,
   .concurrent_section_busy, .flash_we, .flash_erase, .flash_page);
